// ---- core/acl_match_engine.sv ----
// Ingress access list evaluator with count-mode watchdog and event counters.
//
// Behaviour
// RL1: Lowest action pointer wins; one action only.
// RL2: Shared action pointer ORs its groups.
// RL3: Selected match entries are ANDed together.
// RL4: Rule layer mode 00 never matches.
// RL5: Mode picks layer 2, 3 or 4.
// RL6: Layer 2 compares type, MAC or both.
// RL7: Layer 2 select 00 is count mode.
// RL8: Count entry pairs with same-index action.
// RL9: Count value is action bits 29 to 19.
// RL10: Time unit bit picks microsecond or millisecond.
// RL11: Watchdog counts down, event on expiry.
// RL12: Event counter counts packets, wraps at terminal.
// RL13: Direction bit picks destination or source.
// RL14: Equality sense picks equal or unequal.
// RL15: Layer 3 masked single or unmasked pair.
// RL16: Mask bit one excludes address bit.
// RL17: Pair mode: address=source, mask=destination.
// RL18: Layer 4 protocol, TCP, UDP, sequence.
// RL19: Entry has 4-bit pointer, 16-bit mask.
// RL20: All match entries evaluated every packet.
// RL21: Qualifying packet reloads watchdog count.
// RL22: Reserved select codes never match.
// RL23: Count entries give no forwarding action.
`timescale 1ns/1ps
module acl_match_engine (
    // Clock, reset, enable
    input  logic                      i_core_clk,
    input  logic                      i_srst,
    input  logic                      i_ce,
    // Register port
    input  logic [acl_pkg::ADDR_W-1:0] i_addr,
    input  logic [31:0]               i_wdata,
    input  logic                      i_wr,
    input  logic                      i_rd,
    output logic [31:0]               o_rdata,
    // Packet headers from the parser
    input  logic                      i_pkt_valid,
    input  acl_pkg::pkt_hdr_t         i_pkt,
    // Chosen action and count events
    output logic                      o_act_valid,
    output acl_pkg::act_out_t         o_act,
    output logic [15:0]               o_count_event
);
    import acl_pkg::*;

    typedef struct packed {
        match_t [15:0]      m;
        logic [15:0][31:0]  act;
        logic [15:0][19:0]  pr;
        logic [15:0][10:0]  cnt;
        logic [15:0]        arm;
        logic [7:0]         us;
        logic [9:0]         ms;
        logic               ust;
        logic               mst;
        logic [31:0]        rdata;
        logic               av;
        act_out_t           ao;
        logic [15:0]        ev;
    } state_t;

    state_t r;
    state_t next_r;

    logic [15:0] mv;
    logic [15:0] hv;
    logic [15:0] cmode;
    logic [15:0] off_v;
    logic [15:0] rsv_v;
    logic [3:0]  pick;

    // Evaluates one match entry against a header.
    function automatic logic match_fn(input match_t e, input pkt_hdr_t p);
        logic        eqr;
        logic        ok;
        logic [47:0] mac;
        logic [31:0] ip;
        logic [15:0] port;
        eqr  = 1'b0;
        ok   = 1'b1;
        // RL13 direction select
        mac  = e.sd ? p.smac : p.dmac;
        ip   = e.sd ? p.sip : p.dip;
        port = e.sd ? p.sport : p.dport;
        // RL5 layer decode
        case (e.mode)
            MODE_L2: begin
                // RL6 RL7 layer 2 compare
                case (e.sel)
                    L2_TYPE: eqr = p.etype == e.b[31:16];
                    L2_MAC:  eqr = mac == {e.b[15:0], e.a};
                    default: eqr = (p.etype == e.b[31:16]) && (mac == {e.b[15:0], e.a});
                endcase
            end
            MODE_L3: begin
                // RL15 RL16 RL17 address compare
                case (e.sel)
                    L3_MASKED: eqr = ((ip ^ e.a) & ~e.b) == 32'h0000_0000;
                    L3_PAIR:   eqr = (p.sip == e.a) && (p.dip == e.b);
                    // RL22 reserved codes
                    default:   ok = 1'b0;
                endcase
            end
            MODE_L4: begin
                // RL18 layer 4 compare
                case (e.sel)
                    L4_PROTO: eqr = p.proto == e.b[7:0];
                    L4_TCP: begin
                        ok  = p.is_tcp;
                        eqr = (port >= e.a[15:0]) && (port <= e.a[31:16]);
                    end
                    L4_UDP: begin
                        ok  = p.is_udp;
                        eqr = (port >= e.a[15:0]) && (port <= e.a[31:16]);
                    end
                    default: begin
                        ok  = p.is_tcp;
                        eqr = p.seq == e.a;
                    end
                endcase
            end
            // RL4 disabled entry
            default: ok = 1'b0;
        endcase
        // RL14 equality sense
        return ok && (eqr == e.eq);
    endfunction

    // Evaluation of all entries for the current header.
    always_comb begin
        mv    = '0;
        hv    = '0;
        cmode = '0;
        off_v = '0;
        rsv_v = '0;
        pick  = 4'h0;
        for (int i = 0; i < ENT; i++) begin
            // RL20 every entry evaluated
            mv[i]    = match_fn(r.m[i], i_pkt);
            // RL8 count pairing
            cmode[i] = (r.m[i].mode == MODE_L2) && (r.m[i].sel == L2_COUNT);
            off_v[i] = r.m[i].mode == MODE_OFF;
            rsv_v[i] = (r.m[i].mode == MODE_L3)
                       && ((r.m[i].sel == 2'h0) || (r.m[i].sel == 2'h3));
        end
        for (int j = 0; j < ENT; j++) begin
            // RL3 RL19 AND of selected set
            if (r.pr[j][15:0] != 16'h0000 && (r.pr[j][15:0] & ~mv) == 16'h0000) begin
                // RL2 OR into shared action
                hv[r.pr[j][19:16]] = 1'b1;
            end
        end
        // RL23 count entries excluded
        hv = hv & ~cmode;
        // RL1 lowest pointer wins
        for (int k = ENT - 1; k >= 0; k--) begin
            if (hv[k]) begin
                pick = 4'(k);
            end
        end
    end

    // Next state: registers, ticks, counters and outputs.
    always_comb begin
        logic [10:0] cv;
        logic        tick;
        logic [3:0]  wi;
        cv     = '0;
        tick   = 1'b0;
        wi     = i_addr[5:2];
        next_r = r;
        next_r.ev = '0;
        next_r.av = 1'b0;
        // RL10 time bases
        next_r.ust = 1'b0;
        next_r.mst = 1'b0;
        if (r.us == US_CYC - 8'h01) begin
            next_r.us  = 8'h00;
            next_r.ust = 1'b1;
        end else begin
            next_r.us = r.us + 8'h01;
        end
        if (r.ust) begin
            if (r.ms == MS_TICKS - 10'h001) begin
                next_r.ms  = 10'h000;
                next_r.mst = 1'b1;
            end else begin
                next_r.ms = r.ms + 10'h001;
            end
        end
        for (int i = 0; i < ENT; i++) begin
            // RL9 count value field
            cv   = r.act[i][A_CV_HI:A_CV_LO];
            tick = r.act[i][A_TUNIT] ? r.mst : r.ust;
            if (!cmode[i]) begin
                next_r.cnt[i] = 11'h000;
                next_r.arm[i] = 1'b0;
            end else if (r.act[i][A_CALG]) begin
                // RL12 packet event counter
                next_r.arm[i] = 1'b0;
                if (i_pkt_valid && mv[i]) begin
                    if (r.cnt[i] + 11'h001 == cv) begin
                        next_r.cnt[i] = 11'h000;
                        next_r.ev[i]  = 1'b1;
                    end else begin
                        next_r.cnt[i] = r.cnt[i] + 11'h001;
                    end
                end
            end else if (i_pkt_valid && mv[i]) begin
                // RL21 watchdog reload
                next_r.cnt[i] = cv;
                next_r.arm[i] = 1'b1;
            end else if (r.arm[i] && tick) begin
                // RL11 watchdog countdown
                if (r.cnt[i] <= 11'h001) begin
                    next_r.cnt[i] = 11'h000;
                    next_r.arm[i] = 1'b0;
                    next_r.ev[i]  = 1'b1;
                end else begin
                    next_r.cnt[i] = r.cnt[i] - 11'h001;
                end
            end
        end
        // Register writes.
        if (i_wr) begin
            if (i_addr < ACT_BASE) begin
                case (i_addr[3:2])
                    2'h0: begin
                        next_r.m[i_addr[7:4]].mode = i_wdata[F_MODE+1:F_MODE];
                        next_r.m[i_addr[7:4]].sel  = i_wdata[F_SEL+1:F_SEL];
                        next_r.m[i_addr[7:4]].sd   = i_wdata[F_SD];
                        next_r.m[i_addr[7:4]].eq   = i_wdata[F_EQ];
                    end
                    2'h1:    next_r.m[i_addr[7:4]].a = i_wdata;
                    2'h2:    next_r.m[i_addr[7:4]].b = i_wdata;
                    default: next_r.m[i_addr[7:4]].a = r.m[i_addr[7:4]].a;
                endcase
            end else if (i_addr < PROC_BASE) begin
                next_r.act[wi] = i_wdata;
                // A new action word restarts its watchdog.
                next_r.cnt[wi] = i_wdata[A_CV_HI:A_CV_LO];
                next_r.arm[wi] = cmode[wi] && !i_wdata[A_CALG];
                if (i_wdata[A_CALG]) begin
                    next_r.cnt[wi] = 11'h000;
                end
            end else if (i_addr < CNT_BASE) begin
                next_r.pr[wi] = i_wdata[19:0];
            end
        end
        // Register reads, data in the following cycle.
        next_r.rdata = RST_WORD;
        if (i_rd) begin
            if (i_addr < ACT_BASE) begin
                case (i_addr[3:2])
                    2'h0: next_r.rdata = {26'h0, r.m[i_addr[7:4]].eq,
                                          r.m[i_addr[7:4]].sd, r.m[i_addr[7:4]].sel,
                                          r.m[i_addr[7:4]].mode};
                    2'h1:    next_r.rdata = r.m[i_addr[7:4]].a;
                    2'h2:    next_r.rdata = r.m[i_addr[7:4]].b;
                    default: next_r.rdata = RST_WORD;
                endcase
            end else if (i_addr < PROC_BASE) begin
                next_r.rdata = r.act[wi];
            end else if (i_addr < CNT_BASE) begin
                next_r.rdata = {12'h000, r.pr[wi]};
            end else if (i_addr < STAT_ADDR) begin
                next_r.rdata = {20'h00000, r.arm[wi], r.cnt[wi]};
            end else if (i_addr == STAT_ADDR) begin
                next_r.rdata = {27'h0, r.ao.hit, r.ao.idx};
            end
        end
        // Action result one cycle after the header.
        if (i_pkt_valid) begin
            next_r.av      = 1'b1;
            next_r.ao.hit  = hv != 16'h0000;
            next_r.ao.idx  = pick;
            next_r.ao.word = (hv != 16'h0000) ? r.act[pick] : RST_WORD;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            r <= '0;
        end else if (i_ce) begin
            r <= next_r;
        end
    end

    assign o_rdata       = r.rdata;
    assign o_act_valid   = r.av;
    assign o_act         = r.ao;
    assign o_count_event = r.ev;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_srst);

    chk_disabled_false: assert property ((mv & off_v) == 16'h0000) // RL4
        else $error("disabled match entry reported true");
    chk_reserved_false: assert property ((mv & rsv_v) == 16'h0000) // RL22
        else $error("reserved select code reported true");
    chk_count_no_act: assert property ((hv & cmode) == 16'h0000) // RL23
        else $error("count entry produced an action");
    chk_lowest_pick: assert property (i_ce && i_pkt_valid && hv != 16'h0000 // RL1
        |=> o_act.hit && ($past(hv) & ((16'h0001 << o_act.idx) - 16'h0001)) == 16'h0000)
        else $error("action not the lowest pointer");
    chk_group_and: assert property (r.pr[0][15:0] != 16'h0000 // RL3
        && (r.pr[0][15:0] & ~mv) == 16'h0000 && !cmode[r.pr[0][19:16]]
        |-> hv[r.pr[0][19:16]])
        else $error("true group did not select its action");
    chk_type_sense: assert property (r.m[0].mode == MODE_L2 && r.m[0].sel == L2_TYPE // RL14
        && i_pkt.etype == r.m[0].b[31:16] |-> mv[0] == r.m[0].eq)
        else $error("type compare ignored equality sense");
    chk_wdog_reload: assert property (i_ce && !i_wr && cmode[0] && !r.act[0][A_CALG] // RL21
        && i_pkt_valid && mv[0] |=> r.arm[0] && r.cnt[0] == $past(r.act[0][A_CV_HI:A_CV_LO]))
        else $error("watchdog not reloaded by packet");
    chk_wdog_expire: assert property (r.ev[0] && !r.act[0][A_CALG] // RL11
        |-> !r.arm[0] && $past(r.ust || r.mst))
        else $error("watchdog event without tick");
    chk_evt_wrap: assert property (r.ev[0] && r.act[0][A_CALG] |-> r.cnt[0] == 11'h000) // RL12
        else $error("event counter did not reset");

    cov_hit: cover property (o_act_valid && o_act.hit);
    cov_or_pick: cover property (i_pkt_valid && hv[0] && hv[1]);
    cov_wdog: cover property (r.ev[0] && !r.act[0][A_CALG]);
    cov_evt: cover property (r.ev[0] && r.act[0][A_CALG]);
endmodule

// ---- pkg/acl_pkg.sv ----
// Constants and carrier types of the access list match engine.
package acl_pkg;
    localparam int          ENT        = 16;
    localparam int          ADDR_W     = 10;
    localparam logic [1:0]  MODE_OFF   = 2'h0;
    localparam logic [1:0]  MODE_L2    = 2'h1;
    localparam logic [1:0]  MODE_L3    = 2'h2;
    localparam logic [1:0]  MODE_L4    = 2'h3;
    localparam logic [1:0]  L2_COUNT   = 2'h0;
    localparam logic [1:0]  L2_TYPE    = 2'h1;
    localparam logic [1:0]  L2_MAC     = 2'h2;
    localparam logic [1:0]  L3_MASKED  = 2'h1;
    localparam logic [1:0]  L3_PAIR    = 2'h2;
    localparam logic [1:0]  L4_PROTO   = 2'h0;
    localparam logic [1:0]  L4_TCP     = 2'h1;
    localparam logic [1:0]  L4_UDP     = 2'h2;
    localparam logic [1:0]  L4_SEQ     = 2'h3;
    // Byte addresses of the register regions.
    localparam logic [9:0]  MATCH_BASE = 10'h000;
    localparam logic [9:0]  ACT_BASE   = 10'h100;
    localparam logic [9:0]  PROC_BASE  = 10'h140;
    localparam logic [9:0]  CNT_BASE   = 10'h180;
    localparam logic [9:0]  STAT_ADDR  = 10'h1C0;
    // Fields of match word 0 and of an action word.
    localparam int          F_MODE     = 0;
    localparam int          F_SEL      = 2;
    localparam int          F_SD       = 4;
    localparam int          F_EQ       = 5;
    localparam int          A_CALG     = 31;
    localparam int          A_TUNIT    = 30;
    localparam int          A_CV_HI    = 29;
    localparam int          A_CV_LO    = 19;
    localparam logic [31:0] RST_WORD   = 32'h0000_0000;
    // Count time bases.
    localparam int          CLK_NS     = 5;
    localparam int          US_NS      = 1000;
    localparam int          MS_US      = 1000;
    localparam logic [7:0]  US_CYC     = 8'(US_NS / CLK_NS);
    localparam logic [9:0]  MS_TICKS   = 10'(MS_US);

    typedef struct packed {
        logic [47:0] dmac;
        logic [47:0] smac;
        logic [15:0] etype;
        logic [31:0] sip;
        logic [31:0] dip;
        logic [7:0]  proto;
        logic        is_tcp;
        logic        is_udp;
        logic [15:0] sport;
        logic [15:0] dport;
        logic [31:0] seq;
    } pkt_hdr_t;

    typedef struct packed {
        logic [1:0]  mode;
        logic [1:0]  sel;
        logic        sd;
        logic        eq;
        logic [31:0] a;
        logic [31:0] b;
    } match_t;

    typedef struct packed {
        logic        hit;
        logic [3:0]  idx;
        logic [31:0] word;
    } act_out_t;
endpackage

// ---- verification/pkt_source.sv ----
// Header source standing in for the ingress parser.
`timescale 1ns/1ps
module pkt_source (
    // Clock
    input  logic              i_core_clk,
    // Request from the bench
    input  logic              i_go,
    input  acl_pkg::pkt_hdr_t i_hdr,
    // Header bus toward the engine
    output logic              o_pkt_valid,
    output acl_pkg::pkt_hdr_t o_pkt
);
    import acl_pkg::*;

    initial begin
        o_pkt_valid = 1'b0;
        o_pkt       = '0;
    end

    // Between packets the header bus toggles so stale fields never look valid.
    always @(posedge i_core_clk) begin
        o_pkt_valid <= i_go;
        o_pkt       <= i_go ? i_hdr : ~o_pkt;
    end
endmodule

// ---- verification/tb_acl_match_engine.sv ----
// Self-checking bench for the access list match engine.
`timescale 1ns/1ps
module tb_acl_match_engine;
    import acl_pkg::*;
    localparam pkt_hdr_t BASE_HDR = '{dmac: 48'h0A0B_0C0D_0E0F, smac: 48'h1122_3344_5566,
        etype: 16'h0800, sip: 32'hC0A8_0001, dip: 32'h0A00_0002, proto: 8'h06,
        is_tcp: 1'b1, is_udp: 1'b0, sport: 16'h1234, dport: 16'h0050, seq: 32'hDEAD_BEEF};
    logic              i_core_clk = 1'b0;
    logic              i_srst     = 1'b1;
    logic              i_ce       = 1'b1;
    logic [ADDR_W-1:0] i_addr     = '0;
    logic [31:0]       i_wdata    = '0;
    logic              i_wr       = 1'b0;
    logic              i_rd       = 1'b0;
    logic [31:0]       o_rdata;
    logic              i_pkt_valid;
    pkt_hdr_t          i_pkt;
    logic              o_act_valid;
    act_out_t          o_act;
    logic [15:0]       o_count_event;
    logic              go         = 1'b0;
    pkt_hdr_t          hdr        = '0;
    logic [15:0]       ev;
    int                mismatches = 0;
    int                num_checks = 0;

    always #2.5 i_core_clk = ~i_core_clk;

    acl_match_engine u_dut (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_ce(i_ce),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_pkt_valid(i_pkt_valid), .i_pkt(i_pkt), .o_act_valid(o_act_valid),
        .o_act(o_act), .o_count_event(o_count_event));

    pkt_source u_src (.i_core_clk(i_core_clk), .i_go(go), .i_hdr(hdr),
        .o_pkt_valid(i_pkt_valid), .o_pkt(i_pkt));

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic reset_dut(input int n);
        @(posedge i_core_clk);
        i_srst <= 1'b1;
        repeat (n) @(posedge i_core_clk);
        i_srst <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_core_clk);
        i_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, output logic [31:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_core_clk);
        i_rd   <= 1'b0;
        #1 d = o_rdata;
    endtask

    function automatic logic [31:0] mw(logic [1:0] m, logic [1:0] s, logic sd, logic eq);
        return {26'h0, eq, sd, s, m};
    endfunction

    task automatic match(input int i, input logic [31:0] w0, a, b);
        wr(10'(MATCH_BASE + 16 * i), w0);
        wr(10'(MATCH_BASE + 16 * i + 4), a);
        wr(10'(MATCH_BASE + 16 * i + 8), b);
    endtask

    task automatic proc(input int j, input logic [3:0] ptr, input logic [15:0] mask);
        wr(10'(PROC_BASE + 4 * j), {12'h000, ptr, mask});
    endtask

    // Action words carry their own index so the chosen entry is visible.
    task automatic acts();
        for (int i = 0; i < 10; i++) begin
            wr(10'(ACT_BASE + 4 * i), {28'h0000_A00, 4'(i)});
        end
    endtask

    task automatic send(input pkt_hdr_t h, input logic hit, input logic [3:0] idx);
        @(posedge i_core_clk);
        go  <= 1'b1;
        hdr <= h;
        @(posedge i_core_clk);
        go  <= 1'b0;
        @(posedge i_core_clk);
        #1 ev = o_count_event;
        chk(o_act_valid, 1'b1);
        chk(o_act.hit, hit);
        chk({o_act.idx, o_act.word}, hit ? {idx, 28'h0000_A00, idx} : 36'h0);
        // The action strobe stands for one cycle only.
        @(posedge i_core_clk);
        #1 chk(o_act_valid, 1'b0);
    endtask

    task automatic t_regs();
        logic [31:0] d;
        chk(o_act, '0);
        wr(10'h000, mw(MODE_L2, L2_TYPE, 1'b1, 1'b1));
        rd(10'h000, d);
        chk(d, 32'h0000_0035);
        // Read data stand for one cycle and then return to zero.
        @(posedge i_core_clk);
        #1 chk(o_rdata, 32'h0);
        rd(10'h00C, d);
        chk(d, 32'h0);
        rd(10'h1FC, d);
        chk(d, 32'h0);
        wr(10'h180, 32'hFFFF_FFFF);
        rd(10'h180, d);
        chk(d, 32'h0);
        rd(ACT_BASE, d);
        chk(d, 32'h0);
    endtask

    task automatic t_l2();
        pkt_hdr_t h;
        reset_dut(2);
        acts();
        match(0, mw(MODE_L2, L2_TYPE, 1'b0, 1'b1), 32'h0, 32'h0800_0000);
        match(1, mw(MODE_L2, L2_MAC, 1'b1, 1'b1), BASE_HDR.smac[31:0], {16'h0, BASE_HDR.smac[47:32]});
        match(2, mw(MODE_L2, 2'h3, 1'b0, 1'b0), BASE_HDR.dmac[31:0], {16'h86DD, BASE_HDR.dmac[47:32]});
        match(4, mw(MODE_OFF, 2'h3, 1'b0, 1'b0), 32'h0, 32'h0);
        proc(0, 4'h5, 16'h0001);
        proc(1, 4'h2, 16'h0002);
        proc(2, 4'h7, 16'h0004);
        proc(3, 4'h0, 16'h0010);
        h = BASE_HDR;
        send(h, 1'b1, 4'h2);
        h.smac[0] = ~h.smac[0];
        send(h, 1'b1, 4'h5);
        h.etype = 16'h86DD;
        send(h, 1'b0, 4'h0);
    endtask

    task automatic t_l3l4();
        pkt_hdr_t h;
        reset_dut(2);
        acts();
        match(0, mw(MODE_L3, L3_MASKED, 1'b0, 1'b1), 32'h0A00_FFFF, 32'h0000_FFFF);
        match(1, mw(MODE_L3, L3_PAIR, 1'b0, 1'b1), BASE_HDR.sip, BASE_HDR.dip);
        match(2, mw(MODE_L4, L4_PROTO, 1'b0, 1'b1), 32'h0, 32'h0000_0006);
        match(3, mw(MODE_L4, L4_SEQ, 1'b0, 1'b1), BASE_HDR.seq, 32'h0);
        match(4, mw(MODE_L3, 2'h0, 1'b0, 1'b0), 32'h0, 32'h0);
        match(5, mw(MODE_L3, 2'h3, 1'b0, 1'b0), 32'h0, 32'h0);
        match(6, mw(MODE_L4, L4_TCP, 1'b0, 1'b1), 32'h0060_0040, 32'h0);
        match(7, mw(MODE_L4, L4_UDP, 1'b0, 1'b1), 32'h0060_0040, 32'h0);
        proc(0, 4'h1, 16'h0011);
        proc(1, 4'h3, 16'h000F);
        proc(2, 4'h3, 16'h000C);
        proc(3, 4'h2, 16'h0020);
        proc(4, 4'h6, 16'h0001);
        proc(5, 4'h8, 16'h0040);
        proc(6, 4'h7, 16'h0080);
        h = BASE_HDR;
        send(h, 1'b1, 4'h3);
        h.dip = 32'h0A00_1234;
        send(h, 1'b1, 4'h3);
        h = BASE_HDR;
        h.seq = 32'h0;
        send(h, 1'b1, 4'h6);
        h.dip = 32'h0A01_0002;
        send(h, 1'b1, 4'h8);
        h.is_tcp = 1'b0;
        h.is_udp = 1'b1;
        send(h, 1'b1, 4'h7);
        h.dport = 16'h0100;
        send(h, 1'b0, 4'h0);
    endtask

    task automatic t_count();
        logic [31:0] d;
        int          n;
        reset_dut(2);
        match(3, mw(MODE_L2, L2_COUNT, 1'b0, 1'b1), BASE_HDR.dmac[31:0],
            {BASE_HDR.etype, BASE_HDR.dmac[47:32]});
        proc(0, 4'h3, 16'h0008);
        wr(10'(ACT_BASE + 12), 32'h8018_0000);
        rd(10'(ACT_BASE + 12), d);
        chk(d, 32'h8018_0000);
        for (int k = 1; k <= 4; k++) begin
            send(BASE_HDR, 1'b0, 4'h0);
            chk(ev, (k == 3) ? 16'h0008 : 16'h0000);
        end
        wr(10'(ACT_BASE + 12), 32'h0018_0000);
        n = 0;
        repeat (300) begin
            @(posedge i_core_clk);
            #1 n += int'(o_count_event[3]);
        end
        chk(n, 0);
        send(BASE_HDR, 1'b0, 4'h0);
        n = 0;
        while (o_count_event[3] !== 1'b1 && n < 700) begin
            @(posedge i_core_clk);
            #1 n++;
        end
        chk(n >= 380 && n <= 610, 1'b1);
    endtask

    initial begin
        repeat (20000) @(posedge i_core_clk);
        mismatches++;
        stop_test();
    end

    initial begin
        reset_dut(10);
        t_regs();
        t_l2();
        t_l3l4();
        t_count();
        stop_test();
    end
endmodule
